// file: slpc_core.sv
// Purpose: sleep entry, wake-up and power-down handshake of a core
// Assumes: wake and interrupt-enable pins come from other domains and are synchronised here
// Notes:   power-down steps are driven by software writes to the command word
// Function
// - a rising nmi edge, a debug request, or an interrupt or event as chosen by event-wait ends sleep.
// - the sleep indicator goes low when sleep is left.
// - a rising nmi edge always wakes the core and selects the nmi handler, unless a debug request is seen in the same cycle.
// - with event-wait at 0 an enabled pending interrupt wakes the core.
// - with event-wait at 1 interrupts do not wake the core.
// - with event-wait at 1 an asserted event wakes the core to the next instruction.
// - a debug request while asleep wakes the core into debug mode.
// - power-down sleep is refused unless interrupts are globally disabled.
// - with a data cache present and the flush bit set in the sleep command, the cache is flushed and the flush awaited before sleep.
// - the sleep-depth setting must be 1 for a deep sleep to be signalled.
// - with coherency on, sleep waits for coherent traffic and snoops, then drops coherency.
// - the sleep-depth output follows the setting only while the indicator is high.
`timescale 1ns/10ps
`include "slpc_defines.svh"

module slpc_core
  import slpc_pkg::*;
#(
  parameter bit HAS_DCACHE = 1'b1
)
(
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic [`SLPC_ADDR_W-1:0] reg_addr,
  input  wire logic [`SLPC_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`SLPC_DATA_W-1:0] reg_rdata,
  input  wire logic                    nmi,
  input  wire logic                    irq_pend,
  input  wire logic                    irq_global_en,
  input  wire logic                    rx_evt,
  input  wire logic                    dbg_req,
  input  wire logic                    bus_idle,
  input  wire logic                    flush_done,
  input  wire logic                    coher_idle,
  output logic                         flush_req,
  output logic                         coher_en,
  output logic                         clk_gate_en,
  output logic                         core_wfi_mode,
  output logic                         core_sleep_value,
  output logic                         wake_nmi,
  output logic                         wake_irq,
  output logic                         wake_dbg,
  output logic                         wake_resume,
  output logic                         pd_refused
);

  // two-flop synchronisers for pins
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       nmi_last;
  logic       nmi_s;
  logic       irq_s;
  logic       evt_s;
  logic       dbg_s;
  logic       gie_s;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sync_a   <= 5'h00;
      sync_b   <= 5'h00;
      nmi_last <= 1'b0;
    end
    else
    begin
      sync_a   <= {irq_global_en, dbg_req, rx_evt, irq_pend, nmi};
      sync_b   <= sync_a;
      nmi_last <= sync_b[0];
    end
  end

  assign nmi_s = sync_b[0];
  assign irq_s = sync_b[1];
  assign evt_s = sync_b[2];
  assign dbg_s = sync_b[3];
  assign gie_s = sync_b[4];

  // control and state registers
  logic           wait_evt;
  logic           depth;
  logic           coher;
  logic           next_wait_evt;
  logic           next_depth;
  logic           next_coher;
  slpc_state_type state;
  slpc_state_type next_state;
  slpc_wake_type  cause;
  slpc_wake_type  next_cause;
  logic [1:0]     ungate_cnt;
  logic [1:0]     next_ungate_cnt;
  logic           refused;
  logic           next_refused;
  logic           pulse;
  logic           next_pulse;
  logic [`SLPC_DATA_W-1:0] next_rdata;

  logic nmi_rise;
  logic irq_wake;
  logic evt_wake;
  logic any_wake;
  logic wr_ctrl;
  logic wr_cmd;
  logic sleep_cmd;
  logic flush_cmd;

  // wake source decode
  assign nmi_rise = nmi_s & ~nmi_last;
  assign irq_wake = ~wait_evt & irq_s;
  assign evt_wake = wait_evt & evt_s;
  assign any_wake = nmi_rise | irq_wake | evt_wake | dbg_s;

  assign wr_ctrl   = reg_wr && (reg_addr == `SLPC_OFS_CTRL);
  assign wr_cmd    = reg_wr && (reg_addr == `SLPC_OFS_CMD);
  assign sleep_cmd = wr_cmd & reg_wdata[`SLPC_BIT_SLEEP_REQ];
  assign flush_cmd = wr_cmd & reg_wdata[`SLPC_BIT_FLUSH_REQ];

  // next-state logic of the sleep sequencer and registers
  always_comb
  begin
    next_wait_evt   = wait_evt;
    next_depth      = depth;
    next_coher      = coher;
    next_state      = state;
    next_cause      = cause;
    next_ungate_cnt = ungate_cnt;
    next_refused    = refused;
    next_pulse      = 1'b0;
    next_rdata      = '0;
    if (wr_ctrl)
    begin
      next_wait_evt = reg_wdata[`SLPC_BIT_WAIT_EVT];
      next_depth    = reg_wdata[`SLPC_BIT_DEPTH];
      next_coher    = reg_wdata[`SLPC_BIT_COHER];
    end
    if (wr_cmd && reg_wdata[`SLPC_BIT_SLEEP_REQ])
    begin
      next_refused = 1'b0;
    end
    unique case (state)
      slpc_run:
      begin
        if (sleep_cmd && depth && gie_s)
        begin
          next_refused = 1'b1;
        end
        else if (sleep_cmd)
        begin
          next_state = (flush_cmd && HAS_DCACHE) ? slpc_flush : slpc_drain;
        end
      end
      slpc_flush:
      begin
        if (flush_done)
        begin
          next_state = slpc_drain;
        end
      end
      slpc_drain:
      begin
        if (bus_idle && (!coher || coher_idle))
        begin
          next_coher = 1'b0;
          next_state = slpc_sleep;
        end
      end
      slpc_sleep:
      begin
        if (any_wake)
        begin
          next_state      = slpc_ungate;
          next_ungate_cnt = 2'(`SLPC_UNGATE_CYCLES);
          if (dbg_s)
            next_cause = slpc_to_debug;
          else if (nmi_rise)
            next_cause = slpc_to_nmi;
          else if (irq_wake)
            next_cause = slpc_to_irq;
          else
            next_cause = slpc_to_resume;
        end
      end
      slpc_ungate:
      begin
        if (ungate_cnt == 2'h0)
        begin
          next_state = slpc_run;
          next_pulse = 1'b1;
        end
        else
        begin
          next_ungate_cnt = ungate_cnt - 2'h1;
        end
      end
      default:
      begin
        next_state = slpc_run;
      end
    endcase
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SLPC_OFS_CTRL:   next_rdata = {29'h0, coher, depth, wait_evt};
        `SLPC_OFS_STATUS: next_rdata = {26'h0, refused, 2'(cause),
                                        (state == slpc_sleep), 2'h0};
        `SLPC_OFS_ID:     next_rdata = `SLPC_ID_VALUE; // arbitrary value
        default:          next_rdata = '0;
      endcase
    end
  end

  // control bits written from the bus
  // the drain step may also drop the coherency bit, so software sees it cleared
  // after every power-down entry and must set it again before the next task
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      {coher, depth, wait_evt} <= `SLPC_CTRL_RESET;
    end
    else
    begin
      wait_evt <= next_wait_evt;
      depth    <= next_depth;
      coher    <= next_coher;
    end
  end

  // sequencer state
  // comes out of reset running, with every unit clock enabled
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= slpc_run;
    end
    else
    begin
      state <= next_state;
    end
  end

  // wake cause, latched on the edge that leaves sleep
  // kept until the next wake so software can read why the core woke
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cause <= slpc_to_resume;
    end
    else
    begin
      cause <= next_cause;
    end
  end

  // ungate counter
  // gives the gated units their settling time before any strobe is raised
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ungate_cnt <= 2'h0;
    end
    else
    begin
      ungate_cnt <= next_ungate_cnt;
    end
  end

  // refusal flag and one-cycle wake strobe
  // the flag holds until the next sleep request so a slow poll still sees it
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      refused <= 1'b0;
      pulse   <= 1'b0;
    end
    else
    begin
      refused <= next_refused;
      pulse   <= next_pulse;
    end
  end

  // read data stands in the cycle after the read strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // the cache flush request stands for the whole flush step
  assign flush_req = (state == slpc_flush);

  // coherency participation follows the control bit until the drain step drops it
  assign coher_en = coher;

  // unit clocks are gated only while asleep; the ungate step turns them back on
  assign clk_gate_en = (state == slpc_sleep);

  // sleep indicator: high only in the sleep state, low from the first wake cycle
  assign core_wfi_mode = (state == slpc_sleep);

  // depth reads 0 unless the indicator is high, so the power unit never sees
  // a stale deep-sleep request while the core runs
  assign core_sleep_value = core_wfi_mode & depth;

  // one-cycle strobes to the pipeline, raised once the clocks run again
  assign wake_nmi    = pulse && (cause == slpc_to_nmi);
  assign wake_irq    = pulse && (cause == slpc_to_irq);
  assign wake_dbg    = pulse && (cause == slpc_to_debug);
  assign wake_resume = pulse && (cause == slpc_to_resume);

  // a refused power-down request is flagged to software
  assign pd_refused = refused;

endmodule

// file: slpc_defines.svh
// Purpose: constants for the sleep / wake-up and power-down controller
// Assumes: one 200 MHz clock, registers on a plain strobe port
// Notes:   offsets are word indices times four
`ifndef SLPC_DEFINES_SVH
`define SLPC_DEFINES_SVH

`define SLPC_ADDR_W        8
`define SLPC_DATA_W        32
`define SLPC_OFS_CTRL      8'h00
`define SLPC_OFS_STATUS    8'h04
`define SLPC_OFS_CMD       8'h08
`define SLPC_OFS_ID        8'h0C
`define SLPC_BIT_WAIT_EVT  0
`define SLPC_BIT_DEPTH     1
`define SLPC_BIT_COHER     2
`define SLPC_BIT_SLEEP_REQ 0
`define SLPC_BIT_FLUSH_REQ 1
`define SLPC_ID_VALUE      32'h0000_5A11
`define SLPC_CTRL_RESET    3'h0
`define SLPC_UNGATE_TIME_NS 10
`define SLPC_CLK_PERIOD_NS  5
`define SLPC_UNGATE_CYCLES ((`SLPC_UNGATE_TIME_NS + `SLPC_CLK_PERIOD_NS - 1) / `SLPC_CLK_PERIOD_NS)

`endif

// file: slpc_pkg.sv
// Purpose: types for the sleep / wake-up and power-down controller
// Assumes: included with slpc_defines.svh
// Notes:   state and wake-cause enums only
package slpc_pkg;
  typedef enum logic [2:0]
  {
    slpc_run,
    slpc_flush,
    slpc_drain,
    slpc_sleep,
    slpc_ungate
  } slpc_state_type;

  typedef enum logic [1:0]
  {
    slpc_to_resume,
    slpc_to_nmi,
    slpc_to_irq,
    slpc_to_debug
  } slpc_wake_type;
endpackage

// file: slpc_core_checker.sv
// Purpose: port checks of slpc_core
// Assumes: one clock, synchronous reset low
// Notes:   wait mode is followed from bus writes
`timescale 1ns/10ps
`include "slpc_defines.svh"

module slpc_core_checker
(
  input wire logic                    mclk,
  input wire logic                    rst_b,
  input wire logic [`SLPC_ADDR_W-1:0] reg_addr,
  input wire logic [`SLPC_DATA_W-1:0] reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    nmi,
  input wire logic                    irq_pend,
  input wire logic                    irq_global_en,
  input wire logic                    rx_evt,
  input wire logic                    dbg_req,
  input wire logic                    core_wfi_mode,
  input wire logic                    core_sleep_value,
  input wire logic                    wake_irq,
  input wire logic                    wake_dbg,
  input wire logic                    wake_resume,
  input wire logic                    pd_refused
);
  logic wevt;
  // follow the wait-for-event setting
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      wevt <= 1'b0;
    else if (reg_wr && reg_addr == `SLPC_OFS_CTRL)
      wevt <= reg_wdata[`SLPC_BIT_WAIT_EVT];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_deep;
    $rose(core_wfi_mode) && core_sleep_value;
  endsequence
  // wake sources, depth output and power-down refusal
  a_depth_gated: assert property (!core_wfi_mode |-> !core_sleep_value)
    else $error("depth shown while awake");
  a_nmi_wakes: assert property (core_wfi_mode && $rose(nmi) |-> ##[1:8] !core_wfi_mode)
    else $error("nmi did not wake");
  a_evt_wakes: assert property (core_wfi_mode && wevt && rx_evt |-> ##[1:8] wake_resume)
    else $error("event did not resume");
  a_dbg_wakes: assert property (core_wfi_mode && dbg_req |-> ##[1:8] wake_dbg)
    else $error("debug request did not wake");
  a_irq_wakes: assert property (core_wfi_mode && !wevt && irq_pend && irq_global_en
    |-> ##[1:8] !core_wfi_mode)
    else $error("interrupt did not wake");
  a_irq_blocked: assert property (wake_irq |-> !wevt)
    else $error("interrupt woke in event mode");
  a_exit_clears: assert property (wake_irq || wake_dbg || wake_resume
    |-> ##[0:2] !core_wfi_mode)
    else $error("indicator kept after wake");
  a_pd_masked: assert property (s_deep |-> !(irq_pend && irq_global_en))
    else $error("deep sleep with live interrupt");
  a_pd_refused: assert property (pd_refused |-> !core_wfi_mode)
    else $error("sleep entered although refused");
endmodule

// file: slpc_pmu_model.sv
// Purpose: power unit and cache beside slpc_core
// Assumes: a flush is answered a few cycles later
// Notes:   power goes only on indicator and depth
`timescale 1ns/10ps

module slpc_pmu_model
(
  input  wire logic mclk,
  input  wire logic core_wfi_mode,
  input  wire logic core_sleep_value,
  input  wire logic flush_req,
  output logic      flush_done,
  output logic      pwr_off
);
  logic [3:0] cnt;
  // answer a flush after a wait, cut power on deep sleep only
  always @(posedge mclk)
  begin
    cnt <= flush_req ? cnt + 4'h1 : 4'h0;
    flush_done <= flush_req && cnt == 4'h6;
    pwr_off <= core_wfi_mode && core_sleep_value;
  end
endmodule

// file: slpc_core_test.sv
// Purpose: self-checking bench of slpc_core
// Assumes: 200 MHz clock, reset low for 5 cycles
// Notes:   wake sources drawn from a fixed seed
`timescale 1ns/10ps
`include "slpc_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t mismatch", $time); end end

module slpc_core_test;
  logic                    mclk, rst_b, reg_wr, reg_rd, nmi, irq_pend, irq_global_en;
  logic                    rx_evt, dbg_req, bus_idle, coher_idle, flush_req, flush_done;
  logic                    coher_en, clk_gate_en, core_wfi_mode, core_sleep_value, pd_refused;
  logic                    wake_nmi, wake_irq, wake_dbg, wake_resume;
  logic [`SLPC_ADDR_W-1:0] reg_addr;
  logic [`SLPC_DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [3:0]              seen;
  logic [2:0]              ctrl;
  logic [1:0]              src;
  int                      error_cnt, cmp_count, seed;
  slpc_core dut (.*);
  slpc_pmu_model pmu (.*, .pwr_off());
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // bus write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // bus read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // expected wake flags {dbg, resume, irq, nmi}
  function automatic logic [3:0] expect_wake(input logic m, input logic [1:0] s);
    if ((s == 2'd1 && m) || (s == 2'd2 && !m))
      return 4'h0;
    return 4'h1 << s;
  endfunction
  task automatic complete_run();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100us;
    error_cnt++;
    complete_run();
  end
  // main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, nmi, irq_pend, irq_global_en, rx_evt, dbg_req} = 8'h00;
    {bus_idle, coher_idle, reg_addr, reg_wdata} = '0;
    {bus_idle, coher_idle} = 2'h3;
    seed = 32'h7738350A;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`SLPC_OFS_ID);
    `CHK(d, `SLPC_ID_VALUE)
    rd(8'hF0);
    // corner: deep sleep with interrupts enabled is refused
    irq_global_en <= 1'b1;
    wr(`SLPC_OFS_CTRL, 32'h2);
    wr(`SLPC_OFS_CMD, 32'h1);
    repeat (10) @(posedge mclk);
    #1;
    `CHK(pd_refused, 1'b1)
    `CHK(core_wfi_mode, 1'b0)
    for (int i = 0; i < 16; i++)
    begin
      ctrl = 3'($random(seed));
      src = i < 4 ? 2'(i) : 2'($random(seed));
      if (src == 2'd1)
        ctrl[1] = 1'b0;
      irq_global_en <= src == 2'd1;
      wr(`SLPC_OFS_CTRL, {29'h0, ctrl});
      wr(`SLPC_OFS_CMD, {30'h0, i[0], 1'b1});
      repeat (30) @(posedge mclk);
      #1;
      `CHK(core_wfi_mode, 1'b1)
      `CHK(core_sleep_value, ctrl[1])
      `CHK(clk_gate_en, 1'b1)
      `CHK(coher_en, 1'b0)
      `CHK(pd_refused, 1'b0)
      `CHK(flush_req, 1'b0)
      @(posedge mclk);
      case (src)
        2'd0: nmi <= 1'b1;
        2'd1: irq_pend <= 1'b1;
        2'd2: rx_evt <= 1'b1;
        default: dbg_req <= 1'b1;
      endcase
      seen = 4'h0;
      repeat (20)
      begin
        @(posedge mclk);
        #1 seen |= {wake_dbg, wake_resume, wake_irq, wake_nmi};
      end
      `CHK(seen, expect_wake(ctrl[0], src))
      `CHK(core_wfi_mode, expect_wake(ctrl[0], src) == 4'h0)
      `CHK(core_sleep_value, ctrl[1] && expect_wake(ctrl[0], src) == 4'h0)
      `CHK(clk_gate_en, expect_wake(ctrl[0], src) == 4'h0)
      @(posedge mclk);
      {nmi, irq_pend, rx_evt} <= 3'h0;
      dbg_req <= 1'b1;
      repeat (20) @(posedge mclk);
      dbg_req <= 1'b0;
      $display("test %0d done", i);
    end
    complete_run();
  end
endmodule

bind slpc_core slpc_core_checker chk (.*);
